// ==== logic/wbm_top.sv ====
// Functional notes
// - data transfers run 8 or 16 bits wide, chosen by a ctrl bit
// - six control outputs, nine address outputs, six ready inputs
// - each vector sets all control levels and a ready condition to wait on
// - a vector may advance the selected fifo and step the address
// - ordered vectors form one waveform moving data between fifo and device, either way
// - control outputs change at most once per interface clock period
// - ready inputs are sampled and may branch the waveform
// - nine-bit address indexes up to 512 bytes, wider is elsewhere
// - software loads a 32-bit transaction count as four byte registers
// - data movement stalls on fifo empty or full until count done
// - count decrements per transaction and reads back the remainder
// - ecc sees master waveform data or slave fifo bytes
// - code corrects single and detects double bit errors
// - mode clear: two 3-byte codes over two 256-byte blocks
// - after second code both results hold until restart written
// - mode set: one code over 512 bytes, second unused, then hold
// - any write to ecc restart restarts accumulation at next byte
// - interface clock is internal 30 or 48 MHz, or external
// - in master mode the engine drives the two-bit fifo select
// - two-bit config picks port, master or slave; port after reset
module wbm_top
  import wbm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        iface_clock,
  output logic [5:0]       wave_ctrl_out,
  output logic [8:0]       wave_addr_out,
  input  wire logic [5:0]  ready_in,
  input  wire logic [15:0] ext_data_in,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  output logic [1:0]       fifo_select,
  output logic [1:0]       iface_config,
  input  wire logic [15:0] fifo_rd_data,
  input  wire logic        fifo_rd_valid,
  output logic             fifo_rd_ready,
  output logic [15:0]      fifo_wr_data,
  output logic             fifo_wr_valid,
  input  wire logic        fifo_wr_ready,
  input  wire logic [7:0]  slave_byte,
  input  wire logic        slave_byte_valid,
  output logic             wave_done
);

  wbm_st_t s_r;
  wbm_st_t s_nxt;

  logic [23:0] ecc_result_first;
  logic [23:0] ecc_result_second;
  logic        ecc_hold;
  logic        ecc_rst;
  logic        ecc_stb;
  logic [7:0]  ecc_byte;
  logic        step;
  logic        cond;
  logic        move;
  logic        avail;
  logic [31:0] v;
  logic [16:0] acc_sum;
  logic        tick;
  logic        master;
  logic        wr_fire;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      wmerge[8*i+:8] = strb[i] ? nw[8*i+:8] : old[8*i+:8];
  endfunction

  function automatic logic is_cnt(input logic [7:0] a);
    is_cnt = (a == `WBM_A_CNT0) || (a == `WBM_A_CNT1) ||
             (a == `WBM_A_CNT2) || (a == `WBM_A_CNT3);
  endfunction

  function automatic logic [1:0] cnt_idx(input logic [7:0] a);
    cnt_idx = 2'((a - `WBM_A_CNT0) >> 2);
  endfunction

  function automatic logic is_vec(input logic [7:0] a);
    is_vec = (a[7:5] == `WBM_A_VEC_HI) && (a[1:0] == 2'b00);
  endfunction

  assign master = (s_r.ctrl[`WBM_C_MODE] == `WBM_M_MASTER);
  assign v      = s_r.vec[s_r.pc];

  assign acc_sum = {1'b0, s_r.acc} + (s_r.ctrl[`WBM_C_CK48] ?
                   17'(`WBM_INC(`WBM_F48_MHZ)) :
                   17'(`WBM_INC(`WBM_F30_MHZ)));
  // external clock edge from synced pin
  assign tick = s_r.ctrl[`WBM_C_CKEXT] ? (s_r.ck2 && !s_r.ck3)
                                       : acc_sum[16];

  assign step = (s_r.st == ST_RUN) && s_r.pend &&
                (s_r.gap >= 3'(`WBM_CTL_MIN_CYC - 1));

  assign cond = &(~v[`WBM_V_MASK] | ~(s_r.rdy2 ^ v[`WBM_V_MATCH]));

  // stall on empty or full fifo
  assign avail = v[`WBM_V_DOUT] ? fifo_rd_valid : fifo_wr_ready;
  assign move  = step && cond && v[`WBM_V_DATA] && avail;

  assign fifo_rd_ready = move && v[`WBM_V_DOUT];
  assign fifo_wr_valid = move && !v[`WBM_V_DOUT];

  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign ecc_rst = wr_fire && (s_r.awaddr == `WBM_A_ECCRST) &&
                   (s_r.awaddr[1:0] == 2'b00);

  // master data or slave fifo bytes
  always_comb begin
    if (s_r.ctrl[`WBM_C_MODE] == `WBM_M_SLAVE) begin
      ecc_stb  = slave_byte_valid;
      ecc_byte = slave_byte;
    end else begin
      ecc_stb  = move && master;
      ecc_byte = v[`WBM_V_DOUT] ? fifo_rd_data[7:0] : s_r.din2[7:0];
    end
  end

  always_comb begin
    s_nxt = s_r;

    s_nxt.ck1  = iface_clock;
    s_nxt.ck2  = s_r.ck1;
    s_nxt.ck3  = s_r.ck2;
    s_nxt.rdy1 = ready_in;
    s_nxt.rdy2 = s_r.rdy1;
    s_nxt.din1 = ext_data_in;
    s_nxt.din2 = s_r.din1;
    s_nxt.acc  = acc_sum[15:0];
    if (s_r.gap != 3'h7)
      s_nxt.gap = s_r.gap + 3'h1;
    if (tick)
      s_nxt.pend = 1'b1;

    // write channel, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;

    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `WBM_OKAY;
      if (s_r.awaddr == `WBM_A_CTRL) begin
        s_nxt.ctrl = 8'(wmerge({24'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb));
      end else if (s_r.awaddr == `WBM_A_TRIG) begin
        if (s_r.st == ST_IDLE && master && s_r.count != 32'h0) begin
          s_nxt.st   = ST_RUN;
          s_nxt.pc   = 3'h0;
          s_nxt.done = 1'b0;
        end
      end else if (is_cnt(s_r.awaddr)) begin
        if (s_r.wstrb[0])
          s_nxt.count[8*cnt_idx(s_r.awaddr)+:8] = s_r.wdata[7:0];
      end else if (s_r.awaddr == `WBM_A_ECCRST) begin
        s_nxt.bresp = `WBM_OKAY;
      end else if (is_vec(s_r.awaddr)) begin
        s_nxt.vec[s_r.awaddr[4:2]] =
          wmerge(s_r.vec[s_r.awaddr[4:2]], s_r.wdata, s_r.wstrb);
      end else begin
        s_nxt.bresp = `WBM_SLVERR;
      end
    end

    // read channel
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `WBM_OKAY;
      s_nxt.rdata  = 32'h0;
      if (s_axi_araddr == `WBM_A_CTRL) begin
        s_nxt.rdata[7:0] = s_r.ctrl;
      end else if (s_axi_araddr == `WBM_A_STAT) begin
        s_nxt.rdata[0]    = (s_r.st == ST_RUN);
        s_nxt.rdata[1]    = s_r.done;
        s_nxt.rdata[2]    = s_r.waiting;
        s_nxt.rdata[3]    = ecc_hold;
        s_nxt.rdata[13:8] = s_r.rdy2;
      end else if (is_cnt(s_axi_araddr)) begin
        s_nxt.rdata[7:0] = s_r.count[8*cnt_idx(s_axi_araddr)+:8];
      end else if (s_axi_araddr == `WBM_A_ECC_RESULT_FIRST) begin
        s_nxt.rdata[23:0] = ecc_result_first;
      end else if (s_axi_araddr == `WBM_A_ECC_RESULT_SECOND) begin
        s_nxt.rdata[23:0] = ecc_result_second;
      end else if (s_axi_araddr == `WBM_A_TRIG ||
                   s_axi_araddr == `WBM_A_ECCRST) begin
        s_nxt.rdata = 32'h0;
      end else if (is_vec(s_axi_araddr)) begin
        s_nxt.rdata = s_r.vec[s_axi_araddr[4:2]];
      end else begin
        s_nxt.rresp = `WBM_SLVERR;
      end
    end

    // waveform engine
    if (step) begin
      s_nxt.pend = 1'b0;
      s_nxt.gap  = 3'h0;
      s_nxt.ctl  = v[`WBM_V_CTL];
      s_nxt.oe   = v[`WBM_V_DOUT];
      s_nxt.waiting = 1'b0;
      if (!cond) begin
        if (v[`WBM_V_BR])
          s_nxt.pc = v[`WBM_V_TGT];
        else
          s_nxt.waiting = 1'b1;
      end else if (v[`WBM_V_DATA] && !avail) begin
        s_nxt.waiting = 1'b1;
      end else begin
        if (move && v[`WBM_V_DOUT]) begin
          // narrow bus drives low byte only
          s_nxt.dout = s_r.ctrl[`WBM_C_BUS16] ? fifo_rd_data
                                              : {8'h00, fifo_rd_data[7:0]};
        end
        if (v[`WBM_V_INCA])
          s_nxt.addr = s_r.addr + 9'h001;
        if (v[`WBM_V_LAST]) begin
          s_nxt.count = s_r.count - 32'h1;
          s_nxt.pc    = 3'h0;
          if (s_r.count == 32'h1) begin
            s_nxt.st   = ST_IDLE;
            s_nxt.done = 1'b1;
          end
        end else begin
          s_nxt.pc = s_r.pc + 3'h1;
        end
      end
    end
    if (!master && s_r.st == ST_RUN)
      s_nxt.st = ST_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r      <= '0;
      s_r.st   <= ST_IDLE;
      s_r.ctrl <= `WBM_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  wbm_ecc u_ecc (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .restart    (ecc_rst),
    .mode512    (s_r.ctrl[`WBM_C_ECC_MODE_SEL]),
    .byte_stb   (ecc_stb),
    .byte_in    (ecc_byte),
    .ecc_first  (ecc_result_first),
    .ecc_second (ecc_result_second),
    .ecc_hold   (ecc_hold)
  );

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  assign wave_ctrl_out = s_r.ctl;
  assign wave_addr_out = s_r.addr;
  assign ext_data_out  = s_r.dout;
  // pins released outside master mode
  assign ext_data_oe   = s_r.oe && master;
  assign fifo_select   = master ? s_r.ctrl[`WBM_C_FSEL] : 2'b00;
  assign iface_config  = s_r.ctrl[`WBM_C_MODE];
  assign fifo_wr_data  = s_r.ctrl[`WBM_C_BUS16] ? s_r.din2
                                                : {8'h00, s_r.din2[7:0]};
  assign wave_done     = s_r.done;

endmodule

// ==== common/wbm_cfg.svh ====
`ifndef WBM_CFG_SVH
`define WBM_CFG_SVH

// register byte offsets
`define WBM_A_CTRL    8'h00
`define WBM_A_TRIG    8'h04
`define WBM_A_STAT    8'h08
`define WBM_A_CNT0    8'h0c
`define WBM_A_CNT1    8'h10
`define WBM_A_CNT2    8'h14
`define WBM_A_CNT3    8'h18
`define WBM_A_ECCRST  8'h1c
`define WBM_A_ECC_RESULT_FIRST    8'h20
`define WBM_A_ECC_RESULT_SECOND    8'h24
`define WBM_A_VEC_HI  3'h2
`define WBM_VEC_N     8

// ctrl register fields
`define WBM_C_MODE    1:0
`define WBM_C_BUS16   2
`define WBM_C_CK48    3
`define WBM_C_CKEXT   4
`define WBM_C_ECC_MODE_SEL    5
`define WBM_C_FSEL    7:6
`define WBM_CTRL_RST  8'h00

// interface modes
`define WBM_M_PORT    2'h0
`define WBM_M_MASTER  2'h2
`define WBM_M_SLAVE   2'h3

// vector word fields
`define WBM_V_CTL     5:0
`define WBM_V_MASK    11:6
`define WBM_V_MATCH   17:12
`define WBM_V_DATA    18
`define WBM_V_INCA    19
`define WBM_V_DOUT    20
`define WBM_V_BR      21
`define WBM_V_TGT     26:24
`define WBM_V_LAST    27

// axi responses
`define WBM_OKAY      2'h0
`define WBM_SLVERR    2'h2

// timing
`define WBM_SYS_MHZ   250
`define WBM_CLK_PS    4000
`define WBM_F30_MHZ   30
`define WBM_F48_MHZ   48
`define WBM_INC(f)    (((f) * 65536) / `WBM_SYS_MHZ)
`define WBM_CTL_MIN_PS 20800
`define WBM_CTL_MIN_CYC \
  ((`WBM_CTL_MIN_PS + `WBM_CLK_PS - 1) / `WBM_CLK_PS)

// ecc block end indices, length minus one
`define WBM_ECC_B256  9'h0ff
`define WBM_ECC_B512  9'h1ff

`endif

// ==== common/wbm_pkg.sv ====
`include "wbm_cfg.svh"

package wbm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } wbm_state_t;

  typedef enum logic [2:0] {
    EP_FIRST  = 3'b001,
    EP_SECOND = 3'b010,
    EP_HOLD   = 3'b100
  } wbm_ecc_phase_t;

  typedef struct packed {
    wbm_ecc_phase_t ph;
    logic [8:0]     idx;
    logic [17:0]    lp;
    logic [5:0]     cp;
    logic [23:0]    ecc_result_first;
    logic [23:0]    ecc_result_second;
  } wbm_ecc_st_t;

  typedef struct packed {
    wbm_state_t                   st;
    logic                         aw_got;
    logic                         w_got;
    logic [7:0]                   awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
    logic [7:0]                   ctrl;
    logic [31:0]                  count;
    logic                         done;
    logic [`WBM_VEC_N-1:0][31:0]  vec;
    logic [2:0]                   pc;
    logic [5:0]                   ctl;
    logic [8:0]                   addr;
    logic [15:0]                  dout;
    logic                         oe;
    logic                         waiting;
    logic [15:0]                  acc;
    logic                         pend;
    logic [2:0]                   gap;
    logic [5:0]                   rdy1;
    logic [5:0]                   rdy2;
    logic [15:0]                  din1;
    logic [15:0]                  din2;
    logic                         ck1;
    logic                         ck2;
    logic                         ck3;
  } wbm_st_t;

endpackage

// ==== logic/wbm_ecc.sv ====
module wbm_ecc
  import wbm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        restart,
  input  wire logic        mode512,
  input  wire logic        byte_stb,
  input  wire logic [7:0]  byte_in,
  output logic [23:0]      ecc_first,
  output logic [23:0]      ecc_second,
  output logic             ecc_hold
);

  wbm_ecc_st_t s_r;
  wbm_ecc_st_t s_nxt;

  function automatic logic par8(input logic [7:0] b, input logic [7:0] m);
    par8 = ^(b & m);
  endfunction

  function automatic logic [23:0] pack(input logic [17:0] lp,
                                       input logic [5:0]  cp);
    pack = {cp, lp};
  endfunction

  logic [17:0] lp_new;
  logic [5:0]  cp_new;
  logic        bp;

  always_comb begin
    s_nxt  = s_r;
    bp     = par8(byte_in, 8'hff);
    lp_new = s_r.lp;
    cp_new = s_r.cp;
    for (int k = 0; k < 9; k++) begin
      if (s_r.idx[k])
        lp_new[2*k+1] = lp_new[2*k+1] ^ bp;
      else
        lp_new[2*k] = lp_new[2*k] ^ bp;
    end
    cp_new = s_r.cp ^ {par8(byte_in, 8'hf0), par8(byte_in, 8'h0f),
                       par8(byte_in, 8'hcc), par8(byte_in, 8'h33),
                       par8(byte_in, 8'haa), par8(byte_in, 8'h55)};
    if (restart) begin
      s_nxt.ph   = EP_FIRST;
      s_nxt.idx  = '0;
      s_nxt.lp   = '0;
      s_nxt.cp   = '0;
      s_nxt.ecc_result_first = '0;
      s_nxt.ecc_result_second = '0;
    end else if (byte_stb && s_r.ph != EP_HOLD) begin
      s_nxt.idx = s_r.idx + 9'h001;
      s_nxt.lp  = lp_new;
      s_nxt.cp  = cp_new;
      if (mode512) begin
        if (s_r.idx == `WBM_ECC_B512) begin
          s_nxt.ecc_result_first = pack(lp_new, cp_new);
          s_nxt.ph   = EP_HOLD;
        end
      end else if (s_r.idx[7:0] == `WBM_ECC_B256) begin
        s_nxt.lp  = '0;
        s_nxt.cp  = '0;
        if (s_r.ph == EP_FIRST) begin
          s_nxt.ecc_result_first = pack({2'b00, lp_new[15:0]}, cp_new);
          s_nxt.ph   = EP_SECOND;
        end else begin
          s_nxt.ecc_result_second = pack({2'b00, lp_new[15:0]}, cp_new);
          s_nxt.ph   = EP_HOLD;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r    <= '0;
      s_r.ph <= EP_FIRST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ecc_first  = s_r.ecc_result_first;
  assign ecc_second = s_r.ecc_result_second;
  assign ecc_hold   = (s_r.ph == EP_HOLD);

endmodule

// ==== verif/wbm_properties.sv ====
module wbm_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [5:0]  wave_ctrl_out,
  input wire logic [8:0]  wave_addr_out,
  input wire logic [1:0]  iface_config,
  input wire logic [15:0] fifo_rd_data,
  input wire logic        fifo_rd_valid,
  input wire logic        fifo_rd_ready,
  input wire logic [15:0] ext_data_out,
  input wire logic        wave_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] ctl_q_r;
  logic [2:0] gap_r;
  logic [7:0] rd_lo;
  assign rd_lo = fifo_rd_data[7:0];
  // saturating count of cycles since the last control edge
  always_ff @(posedge aclk) begin
    ctl_q_r <= wave_ctrl_out;
    if (!aresetn) gap_r <= 3'h7;
    else if (wave_ctrl_out != ctl_q_r) gap_r <= 3'h0;
    else if (gap_r != 3'h7) gap_r <= gap_r + 3'h1;
  end
  // both channels taken, one cycle to merge, then the answer
  a_bresp_follows: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write response");
  a_bresp_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rdata_follows: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_ctl_edge_gap: assert property (
    $changed(wave_ctrl_out) |-> gap_r >= 3'h5)
    else $error("control edges too close");
  a_addr_step_one: assert property (
    $changed(wave_addr_out) |->
    wave_addr_out == 9'($past(wave_addr_out) + 9'h1))
    else $error("address did not step by one");
  a_pop_needs_data: assert property (
    fifo_rd_ready |-> fifo_rd_valid) else $error("pop from empty source");
  a_pop_data_out: assert property (
    fifo_rd_ready |=> ext_data_out[7:0] == $past(rd_lo))
    else $error("popped data not driven");
  a_reset_port_mode: assert property (disable iff (1'b0)
    !aresetn |=> iface_config == 2'h0 && !wave_done && wave_ctrl_out == 6'h0)
    else $error("reset state wrong");
  c_pop: cover property (fifo_rd_ready);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_done: cover property ($rose(wave_done));
endmodule

bind wbm_top wbm_properties u_wbm_properties (.*);

// ==== verif/wbm_periph_model.sv ====
module wbm_periph_model (
  input  wire logic       aclk,
  input  wire logic [5:0] wave_ctrl_out,
  input  wire logic       ext_data_oe,
  input  wire logic [3:0] lag,
  output logic [5:0]      ready_in,
  output logic [15:0]     ext_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0][5:0] pipe_r = '0;
  initial ready_in = 6'h0;
  initial ext_data_in = 16'h0;
  // ready echoes control after a chosen lag
  always @(posedge aclk) begin
    pipe_r <= {pipe_r[14:0], wave_ctrl_out};
    ready_in <= pipe_r[lag];
  end
  // released bus keeps moving so a stale value never matches
  always @(posedge aclk)
    ext_data_in <= ext_data_oe ? ~ext_data_in : ext_data_in + 16'h0103;
endmodule

// ==== verif/wbm_top_tb.sv ====
`include "wbm_cfg.svh"
module wbm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 0, aresetn = 0, iface_clock = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, slave_byte = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0, lag = 4'h2;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fifo_select, iface_config;
  logic [5:0]  wave_ctrl_out, ready_in;
  logic [8:0]  wave_addr_out;
  logic [15:0] ext_data_in, ext_data_out, fifo_wr_data;
  logic [15:0] fifo_rd_data = 16'h1234, last_pop = '0;
  logic        fifo_rd_valid = 0, fifo_rd_ready, fifo_wr_valid;
  logic        fifo_wr_ready = 1, slave_byte_valid = 0;
  logic        ext_data_oe, wave_done;
  logic [7:0]  cfgs [3] = '{8'h4e, 8'h82, 8'hd2};
  logic [3:0]  lags [3] = '{4'h2, 4'h9, 4'h5};
  logic [7:0]  cmask [6] = '{8'h55, 8'haa, 8'h33, 8'hcc, 8'h0f, 8'hf0};
  int          err_count = 0, checks_done = 0;

  wbm_top u_wbm_top (.*);
  wbm_periph_model u_wbm_periph_model (.*);

  initial forever #2 aclk = ~aclk;
  initial forever #32 iface_clock = ~iface_clock;

  // source fifo hands the next word on each pop
  always @(posedge aclk)
    if (fifo_rd_ready && fifo_rd_valid) begin
      last_pop <= fifo_rd_data;
      fifo_rd_data <= fifo_rd_data + 16'h0101;
    end

  task automatic chk(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "wr resp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "rd resp");
    chk(s_axi_rdata & m, e, "rdata");
  endtask

  function automatic logic [31:0] vw(input logic [5:0] c, k, v,
                                     input logic [3:0] f,
                                     input logic [2:0] t,
                                     input logic l);
    return {4'h0, l, t, 2'b00, f, v, k, c};
  endfunction

  function automatic logic [7:0] pb(input int i);
    return 8'(i * 37 + 5);
  endfunction

  // row and column parity, index bits above the block size left clear
  function automatic logic [23:0] ecc_of(input int base, input int n);
    logic [17:0] lp;
    logic [5:0]  cp;
    logic [7:0]  b;
    logic [8:0]  ix;
    lp = '0;
    cp = '0;
    for (int i = 0; i < n; i++) begin
      b = pb(base + i);
      ix = 9'(i);
      for (int k = 0; k < 9; k++)
        if (^b && (k < 8 || n == 512)) lp[2 * k + ix[k]] ^= 1'b1;
      for (int j = 0; j < 6; j++) cp[j] ^= ^(b & cmask[j]);
    end
    return {cp, lp};
  endfunction

  task automatic feed(input int base, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      slave_byte <= pb(base + i);
      slave_byte_valid <= 1'b1;
    end
    @(posedge aclk);
    slave_byte_valid <= 1'b0;
  endtask

  task automatic run_wave(input logic [7:0] cf, input logic [3:0] lg);
    logic [8:0] a0;
    int n;
    a0 = wave_addr_out;
    n = 0;
    lag <= lg;
    wr(`WBM_A_CTRL, {24'h0, cf}, `WBM_OKAY);
    for (int i = 3; i >= 0; i--)
      wr(`WBM_A_CNT0 + 8'(4 * i), (i == 0) ? 32'h3 : 32'h0, `WBM_OKAY);
    wr(`WBM_A_TRIG, 32'h0, `WBM_OKAY);
    repeat (80) @(posedge aclk);
    chk({23'h0, wave_addr_out}, {23'h0, a0}, "stall");
    chk({31'h0, ext_data_oe}, 32'h1, "oe on");
    fifo_rd_valid <= 1'b1;
    while (wave_done !== 1'b1 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    fifo_rd_valid <= 1'b0;
    chk({23'h0, wave_addr_out}, {23'h0, 9'(a0 + 9'h3)}, "addr");
    chk({26'h0, wave_ctrl_out}, 32'h0, "ctl");
    chk({30'h0, fifo_select}, {30'h0, cf[7:6]}, "fsel");
    chk({16'h0, ext_data_out}, cf[2] ? {16'h0, last_pop} :
        {24'h0, last_pop[7:0]}, "dout");
    chk({22'h0, fifo_wr_valid, ext_data_oe,
         fifo_wr_data[15:8] & {8{~cf[2]}}}, 32'h0, "idle pins");
    rd(`WBM_A_CNT0, 32'h0, 32'hffffffff, `WBM_OKAY);
    rd(`WBM_A_STAT, 32'h2, 32'h3, `WBM_OKAY);
    $display("waveform test %h ended", cf);
  endtask

  task automatic ecc_run(input logic m5, input int base);
    wr(`WBM_A_CTRL, m5 ? 32'h23 : 32'h03, `WBM_OKAY);
    wr(`WBM_A_ECCRST, 32'h5a, `WBM_OKAY);
    feed(base, 520);
    rd(`WBM_A_ECC_RESULT_FIRST, {8'h0, ecc_of(base, m5 ? 512 : 256)},
       32'hffffffff, `WBM_OKAY);
    rd(`WBM_A_ECC_RESULT_SECOND, m5 ? 32'h0 : {8'h0, ecc_of(base + 256, 256)},
       32'hffffffff, `WBM_OKAY);
    rd(`WBM_A_STAT, 32'h8, 32'h8, `WBM_OKAY);
    $display("ecc test mode %0d ended", m5);
  endtask

  // hang guard, well above the longest sequence
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`WBM_A_CTRL, 32'h0, 32'hff, `WBM_OKAY);
    chk({30'h0, iface_config}, 32'h0, "cfg");
    rd(8'h3c, 32'h0, 32'hffffffff, `WBM_SLVERR);
    wr(8'h2c, 32'h1, `WBM_SLVERR);
    for (int i = 0; i < 4; i++)
      wr(`WBM_A_CNT0 + 8'(4 * i), 32'h11 * (i + 1), `WBM_OKAY);
    for (int i = 0; i < 4; i++)
      rd(`WBM_A_CNT0 + 8'(4 * i), 32'h11 * (i + 1), 32'hff, `WBM_OKAY);
    $display("register test ended");
    wr(8'h40, vw(6'h01, 6'h00, 6'h00, 4'h0, 3'h0, 1'b0), `WBM_OKAY);
    wr(8'h44, vw(6'h01, 6'h01, 6'h01, 4'h7, 3'h0, 1'b0), `WBM_OKAY);
    wr(8'h48, vw(6'h00, 6'h01, 6'h00, 4'h8, 3'h2, 1'b1), `WBM_OKAY);
    for (int c = 0; c < 3; c++) run_wave(cfgs[c], lags[c]);
    wr(`WBM_A_TRIG, 32'h0, `WBM_OKAY);
    rd(`WBM_A_STAT, 32'h2, 32'h3, `WBM_OKAY);
    ecc_run(1'b0, 0);
    ecc_run(1'b1, 3);
    ecc_run(1'b0, 7);
    complete_run;
  end
endmodule
